/* verilog/touch_pkg.sv */
// constants, register map and types of the touch result packer
package touch_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int TAG_W = 4;
  localparam int SAMPLE_W = 12;
  localparam int BURST_MAX = 4;
  localparam int IDX_W = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AVG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CHEN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CHDIS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CHSR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LAST = 8'h1c;

  // control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TAG_BIT = 2;
  localparam int CTRL_PEN_BIT = 3;
  localparam int CTRL_TRIGGER_SOURCE_SELECT_LSB = 4;
  localparam int TRIGGER_SOURCE_SELECT_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // averaging register fields
  localparam int AVG_W = 8;
  localparam int AVG_TOUCH_AVERAGE_SETTING_LSB = 0;
  localparam int TOUCH_AVERAGE_SETTING_W = 2;
  localparam int AVG_TOUCH_FREQUENCY_RATIO_LSB = 4;
  localparam int TOUCH_FREQUENCY_RATIO_W = 4;
  localparam logic [AVG_W-1:0] AVG_RESET = 8'h00;

  // status and mask bits
  localparam int ST_W = 3;
  localparam int ST_DONE = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_OVERRUN = 2;
  localparam logic [ST_W-1:0] ST_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TM_NONE = 2'h0,
    TM_FOUR_WIRE = 2'h1,
    TM_FOUR_WIRE_PRESS = 2'h2,
    TM_FIVE_WIRE = 2'h3
  } touch_mode_t;

  localparam logic [TAG_W-1:0] TAG_X = 4'h0;
  localparam logic [TAG_W-1:0] TAG_Y = 4'h1;
  localparam logic [TAG_W-1:0] TAG_Z1 = 4'h2;
  localparam logic [TAG_W-1:0] TAG_Z2 = 4'h3;
  localparam logic [TAG_W-1:0] TAG_NONE = 4'h0;

  localparam logic [IDX_W:0] WORDS_XY = 3'h2;
  localparam logic [IDX_W:0] WORDS_PRESS = 3'h4;

  // interrupt controller source that irq is wired to
  localparam int IRQ_SOURCE_ID = 40;
endpackage

/* verilog/touch_burst.sv */
// half-word burst sequencer feeding the memory buffer
`timescale 1ns/100ps
`default_nettype none
module touch_burst (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire touch_pkg::touch_mode_t mode,
  input wire logic tag_en,
  input wire logic [touch_pkg::SAMPLE_W-1:0] x_position_result,
  input wire logic [touch_pkg::SAMPLE_W-1:0] y_position_result,
  input wire logic [touch_pkg::SAMPLE_W-1:0] first_pressure_sample,
  input wire logic [touch_pkg::SAMPLE_W-1:0] second_pressure_sample,
  output logic out_valid,
  output logic [touch_pkg::HALF_W-1:0] out_data,
  input wire logic out_ready,
  output logic busy,
  output logic last_word
);
  import touch_pkg::*;

  typedef enum logic {S_IDLE, S_SEND} burst_state_t;

  burst_state_t state_q;
  logic [HALF_W-1:0] word_q [BURST_MAX];
  logic [HALF_W-1:0] load_word [BURST_MAX];
  logic [IDX_W:0] count_q;
  logic [IDX_W:0] idx_q;
  logic [IDX_W:0] idx_next;
  logic fire;

  function automatic logic [HALF_W-1:0] pack(
    input logic en, input logic [TAG_W-1:0] tag,
    input logic [SAMPLE_W-1:0] s);
    pack = {(en ? tag : TAG_NONE), s};
  endfunction

  // only position and pressure samples exist here; calibration never enters
  always_comb begin
    load_word[0] = pack(tag_en, TAG_X, x_position_result);
    load_word[1] = pack(tag_en, TAG_Y, y_position_result);
    load_word[2] = pack(tag_en, TAG_Z1, first_pressure_sample);
    load_word[3] = pack(tag_en, TAG_Z2, second_pressure_sample);
  end

  assign out_valid = (state_q == S_SEND);
  assign busy = (state_q == S_SEND);
  assign fire = out_valid && out_ready;
  assign idx_next = idx_q + 3'h1;
  assign last_word = out_valid && (idx_next == count_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else if (load && state_q == S_IDLE) begin
      state_q <= S_SEND;
    end else if (fire && last_word) begin
      state_q <= S_IDLE;
    end
  end

  // words of one trigger leave back to back, nothing can slip in
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_q <= '0;
      count_q <= WORDS_XY;
      out_data <= '0;
      for (int i = 0; i < BURST_MAX; i++) begin
        word_q[i] <= '0;
      end
    end else if (load && state_q == S_IDLE) begin
      idx_q <= '0;
      count_q <= (mode == TM_FOUR_WIRE_PRESS) ? WORDS_PRESS : WORDS_XY;
      out_data <= load_word[0];
      for (int i = 0; i < BURST_MAX; i++) begin
        word_q[i] <= load_word[i];
      end
    end else if (fire && !last_word) begin
      idx_q <= idx_next;
      out_data <= word_q[idx_next[IDX_W-1:0]];
    end
  end
endmodule
`default_nettype wire

/* verilog/touch_result_packer.sv */
// touch result packer: trigger, decimation, tagging, registers, interrupt
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module touch_result_packer #(
  parameter int NUM_CH = 12,
  parameter int NUM_HW_TRIG = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [touch_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [touch_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [touch_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [touch_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [touch_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_trigger_input,
  input wire logic [NUM_HW_TRIG-1:0] hw_trigger,
  input wire logic [touch_pkg::SAMPLE_W-1:0] x_position_result,
  input wire logic [touch_pkg::SAMPLE_W-1:0] y_position_result,
  input wire logic [touch_pkg::SAMPLE_W-1:0] first_pressure_sample,
  input wire logic [touch_pkg::SAMPLE_W-1:0] second_pressure_sample,
  input wire logic [NUM_CH-1:0] digital_function_sel,
  output logic [NUM_CH-1:0] analog_route_en,
  output logic conv_start,
  output logic buf_valid,
  output logic [touch_pkg::HALF_W-1:0] buf_data,
  input wire logic buf_ready,
  output logic pen_detection_enable,
  output logic fault_out,
  output logic irq
);
  import touch_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [AVG_W-1:0] avg_q;
  logic [NUM_CH-1:0] chen_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [HALF_W-1:0] last_q;
  logic [NUM_CH-1:0] route_q;
  logic trig_prev_q;
  logic conv_start_q;
  logic fault_q;
  logic [TOUCH_FREQUENCY_RATIO_W-1:0] skip_cnt_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;

  touch_mode_t mode;
  logic [TRIGGER_SOURCE_SELECT_W-1:0] trigger_source_select;
  logic tag_en;
  logic [TOUCH_FREQUENCY_RATIO_W-1:0] ratio;
  logic sel_trig;
  logic trig_evt;
  logic emit;
  logic burst_load;
  logic burst_busy;
  logic burst_last;
  logic overrun_evt;
  logic skip_evt;
  logic done_evt;
  logic wr_fire;
  logic rd_fire;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wbits;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;

  // byte strobes to a bit mask, shared by every writable register
  function automatic logic [DATA_W-1:0] strb_mask(
    input logic [DATA_W/8-1:0] strb);
    for (int b = 0; b < DATA_W / 8; b++) begin
      strb_mask[b*8 +: 8] = {8{strb[b]}};
    end
  endfunction

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
    input logic [DATA_W-1:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = (a == OFS_CTRL) || (a == OFS_AVG) || (a == OFS_CHEN) ||
                 (a == OFS_CHDIS) || (a == OFS_CHSR) ||
                 (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_LAST);
  endfunction

  assign mode = touch_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign tag_en = ctrl_q[CTRL_TAG_BIT];
  assign trigger_source_select = ctrl_q[CTRL_TRIGGER_SOURCE_SELECT_LSB +: TRIGGER_SOURCE_SELECT_W];
  // pen detection is only passed on; the packing never looks at it
  assign pen_detection_enable = ctrl_q[CTRL_PEN_BIT];

  // write channel: address and data are taken together
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wmask = strb_mask(s_axi_wstrb);
  assign wbits = s_axi_wdata & wmask;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= known_addr(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      avg_q <= AVG_RESET;
      mask_q <= ST_RESET;
    end else if (wr_fire) begin
      if (s_axi_awaddr == OFS_CTRL) begin
        ctrl_q <= CTRL_W'(merge(DATA_W'(ctrl_q), s_axi_wdata, wmask));
      end
      if (s_axi_awaddr == OFS_AVG) begin
        avg_q <= AVG_W'(merge(DATA_W'(avg_q), s_axi_wdata, wmask));
      end
      if (s_axi_awaddr == OFS_MASK) begin
        mask_q <= ST_W'(merge(DATA_W'(mask_q), s_axi_wdata, wmask));
      end
    end
  end

  // enable and disable are write-one, so no read-modify-write is needed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chen_q <= '0;
    end else if (wr_fire && s_axi_awaddr == OFS_CHEN) begin
      chen_q <= chen_q | wbits[NUM_CH-1:0];
    end else if (wr_fire && s_axi_awaddr == OFS_CHDIS) begin
      chen_q <= chen_q & ~wbits[NUM_CH-1:0];
    end
  end

  // a digital function on the line always wins over the analog path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      route_q <= '0;
    end else begin
      route_q <= chen_q & ~digital_function_sel;
    end
  end
  assign analog_route_en = route_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_q <= DATA_W'(ctrl_q);
        OFS_AVG: rdata_q <= DATA_W'(avg_q);
        OFS_CHSR: rdata_q <= DATA_W'(chen_q);
        OFS_STATUS: rdata_q <= DATA_W'(status_q);
        OFS_MASK: rdata_q <= DATA_W'(mask_q);
        OFS_LAST: rdata_q <= DATA_W'(last_q);
        default: rdata_q <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // trigger source: zero picks the pin, n picks internal trigger n-1
  always_comb begin
    sel_trig = external_trigger_input;
    for (int t = 0; t < NUM_HW_TRIG; t++) begin
      if (int'(trigger_source_select) == t + 1) begin
        sel_trig = hw_trigger[t];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_prev_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      trig_prev_q <= sel_trig;
      conv_start_q <= trig_evt;
    end
  end
  assign trig_evt = sel_trig && !trig_prev_q;
  assign conv_start = conv_start_q;

  // decimation: one burst per ratio+1 triggers
  assign ratio = avg_q[AVG_TOUCH_FREQUENCY_RATIO_LSB +: TOUCH_FREQUENCY_RATIO_W] |
                 TOUCH_FREQUENCY_RATIO_W'((4'h1 << avg_q[AVG_TOUCH_AVERAGE_SETTING_LSB +: TOUCH_AVERAGE_SETTING_W]) - 4'h1);
  assign emit = trig_evt && (skip_cnt_q == ratio) && (mode != TM_NONE);
  assign skip_evt = trig_evt && !emit;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      skip_cnt_q <= '0;
    end else if (trig_evt) begin
      skip_cnt_q <= (skip_cnt_q >= ratio) ? '0 : skip_cnt_q + 4'h1;
    end
  end

  // a burst still draining means the new result is lost: fault, not merge
  assign burst_load = emit && !burst_busy;
  assign overrun_evt = emit && burst_busy;

  touch_burst u_burst (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(burst_load),
    .mode(mode),
    .tag_en(tag_en),
    .x_position_result(x_position_result),
    .y_position_result(y_position_result),
    .first_pressure_sample(first_pressure_sample),
    .second_pressure_sample(second_pressure_sample),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_ready),
    .busy(burst_busy),
    .last_word(burst_last)
  );

  assign done_evt = buf_valid && buf_ready && burst_last;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_q <= '0;
    end else if (buf_valid && buf_ready) begin
      last_q <= buf_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= overrun_evt;
    end
  end
  assign fault_out = fault_q;

  // sticky status: a set in the clearing cycle survives
  always_comb begin
    st_set = '0;
    st_set[ST_DONE] = done_evt;
    st_set[ST_SKIP] = skip_evt;
    st_set[ST_OVERRUN] = overrun_evt;
    st_clr = (wr_fire && s_axi_awaddr == OFS_STATUS) ? wbits[ST_W-1:0] : '0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= ST_RESET;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end
  // one level line to the interrupt controller source IRQ_SOURCE_ID
  assign irq = |(status_q & mask_q);

  // helper logic for the checks below
  logic [IDX_W:0] words_q;
  logic tag_q;
  logic press_q;
  logic buf_take;
  assign buf_take = buf_valid && buf_ready;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      words_q <= '0;
      tag_q <= 1'b0;
      press_q <= 1'b0;
    end else if (burst_load) begin
      words_q <= '0;
      tag_q <= tag_en;
      press_q <= (mode == TM_FOUR_WIRE_PRESS);
    end else if (buf_valid && buf_ready) begin
      words_q <= words_q + 3'h1;
    end
  end

  AST_XY_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(buf_valid) && !press_q |-> words_q == WORDS_XY)
    else $error("position burst did not hold two half-words");
  AST_PRESS_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(buf_valid) && press_q |-> words_q == WORDS_PRESS)
    else $error("pressure burst did not hold four half-words");
  AST_SKIP: assert property (@(posedge clk_sys) disable iff (rst)
    trig_evt && skip_cnt_q != ratio |-> !burst_load ##1 !$rose(buf_valid))
    else $error("decimated trigger still produced data");
  AST_TAG_XY: assert property (@(posedge clk_sys) disable iff (rst)
    buf_valid && tag_q && words_q < WORDS_XY
    |-> buf_data[HALF_W-1 -: TAG_W] == TAG_W'(words_q))
    else $error("position tag wrong");
  AST_TAG_Z: assert property (@(posedge clk_sys) disable iff (rst)
    buf_valid && tag_q && press_q && words_q >= WORDS_XY
    |-> buf_data[HALF_W-1 -: TAG_W] == TAG_W'(words_q))
    else $error("pressure tag wrong");
  AST_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> analog_route_en ==
      ($past(chen_q) & ~$past(digital_function_sel)))
    else $error("analog routing ignores enable or digital select");
  AST_START: assert property (@(posedge clk_sys) disable iff (rst)
    trig_evt |=> conv_start ##1 !conv_start)
    else $error("trigger did not start one conversion");
  AST_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
    emit && burst_busy |=> fault_out &&
      words_q == $past(words_q) + (IDX_W+1)'($past(buf_take)))
    else $error("lost burst did not raise fault");
  AST_CONSEC: assert property (@(posedge clk_sys) disable iff (rst)
    buf_valid && !buf_ready |=> buf_valid && $stable(buf_data))
    else $error("buffered half-word changed before it was taken");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
    done_evt && mask_q[ST_DONE] &&
      !(wr_fire && s_axi_awaddr == OFS_MASK) |=> irq)
    else $error("unmasked completion raised no interrupt");

  COV_PRESS: cover property (@(posedge clk_sys) disable iff (rst)
    done_evt && press_q && tag_q);
  COV_SKIP: cover property (@(posedge clk_sys) disable iff (rst)
    skip_evt ##[1:50] burst_load);
  COV_OVERRUN: cover property (@(posedge clk_sys) disable iff (rst)
    overrun_evt);
endmodule
`default_nettype wire

/* test/buf_consumer.sv */
// memory buffer consumer model with selectable stall behaviour
`timescale 1ns/100ps
`default_nettype none
module buf_consumer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] stall_mode,
  input wire logic pen_detection_enable,
  input wire logic buf_valid,
  output logic buf_ready
);
  logic [7:0] rnd_q;
  logic pen_seen_q;
  // ready changes only after an edge, so a half-word is never half taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rnd_q <= 8'h5b;
      buf_ready <= 1'b0;
    end else begin
      rnd_q <= {rnd_q[6:0], rnd_q[7] ^ rnd_q[5] ^ rnd_q[4] ^ rnd_q[3]};
      buf_ready <= (stall_mode == 2'h0) | ((stall_mode == 2'h1) & rnd_q[0]);
    end
  end
  // pen state is only noted: post-processing may ignore it
  always_ff @(posedge clk_sys) begin
    if (buf_valid && buf_ready) begin
      pen_seen_q <= pen_detection_enable;
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the touch result packer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import touch_pkg::*;
  logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, ext_trg;
  logic awready, wready, bvalid, arready, rvalid, buf_valid, buf_ready;
  logic conv_start, pen_en, fault_out, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, stall;
  logic [6:0] hw_trg;
  logic [11:0] xs, ys, z1s, z2s, dsel, route;
  logic [15:0] buf_data, lfsr_q;
  logic [15:0] q[$];
  int fails, n_checks, cycles, n_conv, n_fault;

  touch_result_packer dut (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_trigger_input(ext_trg), .hw_trigger(hw_trg),
    .x_position_result(xs), .y_position_result(ys),
    .first_pressure_sample(z1s), .second_pressure_sample(z2s),
    .digital_function_sel(dsel), .analog_route_en(route),
    .conv_start(conv_start), .buf_valid(buf_valid), .buf_data(buf_data),
    .buf_ready(buf_ready), .pen_detection_enable(pen_en),
    .fault_out(fault_out), .irq(irq));

  buf_consumer partner (.clk_sys(clk_sys), .rst(rst), .stall_mode(stall),
    .pen_detection_enable(pen_en), .buf_valid(buf_valid),
    .buf_ready(buf_ready));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // the edge sees pre-update values, so takes are counted once each
  always @(posedge clk_sys) begin
    cycles++;
    if (buf_valid && buf_ready) q.push_back(buf_data);
    if (conv_start) n_conv++;
    if (fault_out) n_fault++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  function automatic logic [15:0] hw(input logic [3:0] t,
      input logic [11:0] s, input logic tg);
    return {tg ? t : 4'h0, s};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] st = 4'hf);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk_sys iff awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk_sys iff bvalid);
    bready <= 1'b0;
    check(bresp, a < 8'h20 ? RESP_OKAY : RESP_SLVERR);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk_sys iff arready);
    arvalid <= 1'b0;
    @(posedge clk_sys iff rvalid);
    rready <= 1'b0;
    check(rresp, a < 8'h20 ? RESP_OKAY : RESP_SLVERR);
    check(rdata, exp);
  endtask

  task automatic trig(input int sel);
    @(posedge clk_sys);
    if (sel == 0) ext_trg <= 1'b1;
    else hw_trg[sel-1] <= 1'b1;
    @(posedge clk_sys);
    ext_trg <= 1'b0;
    hw_trg <= 7'h00;
  endtask

  task automatic wait_words(input int n);
    for (int k = 0; k < 200 && q.size() < n; k++) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    check(q.size(), n);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [1:0] mode;
    logic tg;
    logic [15:0] r;
    int sel, n, c;
    {awvalid, wvalid, bready, arvalid, rready, ext_trg} = 6'h00;
    {awaddr, araddr, wdata, wstrb, hw_trg} = '0;
    {xs, ys, z1s, z2s, dsel} = '0;
    stall = 2'h1;
    lfsr_q = 16'h004c;
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_AVG, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_MASK, 32'h0);
    rdc(8'h20, 32'h0);
    wr(8'h24, 32'hffffffff);
    check(IRQ_SOURCE_ID, 40);
    note("reset");
    dsel <= 12'h0f0;
    wr(OFS_CHEN, 32'hff3);
    wr(OFS_CHDIS, 32'h003);
    rdc(OFS_CHSR, 32'hff0);
    @(negedge clk_sys);
    check(route, 12'hf00);
    @(posedge clk_sys);
    r = rnd();
    dsel <= r[11:0];
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check(route, 12'hff0 & ~r[11:0]);
    note("channels");
    for (int i = 0; i < 6; i++) begin
      mode = 2'(1 + i % 3);
      tg = i >= 3;
      sel = rnd() % 8;
      wr(OFS_CTRL, {25'h0, sel[2:0], tg ^ mode[0], tg, mode});
      check(pen_en, tg ^ mode[0]);
      @(posedge clk_sys);
      xs <= 12'(rnd());
      ys <= 12'(rnd());
      z1s <= 12'(rnd());
      z2s <= 12'(rnd());
      c = n_conv;
      trig((sel + 1) % 8);
      wait_words(0);
      trig(sel);
      n = (mode == TM_FOUR_WIRE_PRESS) ? 4 : 2;
      wait_words(n);
      check(n_conv, c + 1);
      check(q.pop_front(), hw(TAG_X, xs, tg));
      check(q.pop_front(), hw(TAG_Y, ys, tg));
      if (n == 4) begin
        check(q.pop_front(), hw(TAG_Z1, z1s, tg));
        check(q.pop_front(), hw(TAG_Z2, z2s, tg));
      end
      q.delete();
    end
    wr(OFS_CTRL, 32'h0);
    trig(0);
    wait_words(0);
    note("modes");
    wr(OFS_STATUS, 32'h7);
    wr(OFS_CTRL, 32'h1);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_AVG, j ? 32'h02 : 32'h20);
      n = j ? 4 : 3;
      for (int k = 0; k < 2 * n; k++) begin
        trig(0);
        repeat (4) @(posedge clk_sys);
      end
      wait_words(4);
      repeat (2) begin
        check(q.pop_front(), hw(TAG_X, xs, 1'b0));
        check(q.pop_front(), hw(TAG_Y, ys, 1'b0));
      end
    end
    rdc(OFS_STATUS, 32'h3);
    wr(OFS_AVG, 32'h0);
    note("decimation");
    @(negedge clk_sys);
    check(irq, 1'b0);
    wr(OFS_MASK, 32'h3);
    @(negedge clk_sys);
    check(irq, 1'b1);
    wr(OFS_MASK, 32'h7, 4'he);
    rdc(OFS_MASK, 32'h3);
    wr(OFS_STATUS, 32'h1);
    @(negedge clk_sys);
    check(irq, 1'b1);
    wr(OFS_STATUS, 32'h2);
    @(negedge clk_sys);
    check(irq, 1'b0);
    note("interrupt");
    wr(OFS_MASK, 32'h4);
    stall <= 2'h2;
    c = n_fault;
    trig(0);
    trig(0);
    repeat (4) @(posedge clk_sys);
    check(n_fault, c + 1);
    @(negedge clk_sys);
    check(irq, 1'b1);
    @(posedge clk_sys);
    stall <= 2'h0;
    wait_words(2);
    check(q.pop_front(), hw(TAG_X, xs, 1'b0));
    check(q.pop_front(), hw(TAG_Y, ys, 1'b0));
    rdc(OFS_STATUS, 32'h5);
    note("overrun");
    summarize();
  end
endmodule
`default_nettype wire
